// file: bench/host_model.sv
// Purpose: host controller driving the serial pins of the driver
// Assumes: link clock of 125 ns period, idle low between frames
// Notes: data line shows the inverse of the last bit when released
`timescale 1ns/1ps
module host_model
  import latch_driver_pkg::*;
(
  output logic shift_clock,
  output logic shift_data_in,
  output logic latch_clock
);
  initial begin
    shift_clock = 1'b0;
    shift_data_in = 1'b0;
    latch_clock = 1'b0;
  end

  // first bit sent ends on the last output; pins move by nba so that
  // a change landing on a clk edge is never raced by the samplers
  task automatic send(input logic [STAGE_W-1:0] word, input bit do_latch);
    for (int i = STAGE_W - 1; i >= 0; i--) begin
      shift_data_in <= word[i];
      #62.5 shift_clock <= 1'b1;
      #62.5 shift_clock <= 1'b0;
    end
    shift_data_in <= ~word[0];
    if (do_latch) begin
      pulse_latch();
    end else begin
      #62.5;
    end
  endtask : send

  // one latch pulse, no shifting
  task automatic pulse_latch();
    #62.5 latch_clock <= 1'b1;
    #62.5 latch_clock <= 1'b0;
    #62.5;
  endtask : pulse_latch
endmodule : host_model

// file: bench/testbench.sv
// Purpose: self-checking bench for the latched output driver
// Assumes: host_model drives the serial pins
// Notes: outputs sampled on the falling clk edge
`timescale 1ns/1ps
module testbench;
  import latch_driver_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clear_n = 1'b1;
  logic out_enable_n = 1'b1;
  wire logic shift_clock;
  wire logic latch_clock;
  wire logic shift_data_in;
  logic cascade_data_out;
  logic [STAGE_W-1:0] sink_output;
  logic latch_ready;
  int mismatches = 0;
  int samples_checked = 0;

  latch_driver latch_driver_inst (.clk(clk), .rst_b(rst_b),
    .shift_clock(shift_clock), .latch_clock(latch_clock),
    .shift_data_in(shift_data_in), .clear_n(clear_n),
    .out_enable_n(out_enable_n), .cascade_data_out(cascade_data_out),
    .sink_output(sink_output), .latch_ready(latch_ready));
  host_model host_model_inst (.shift_clock(shift_clock),
    .shift_data_in(shift_data_in), .latch_clock(latch_clock));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_sink(input logic [7:0] exp);
    for (int i = 0; i < 40 && sink_output !== exp; i++) @(negedge clk);
  endtask : wait_sink

  task automatic t_words();
    logic [7:0] words [4] = '{8'ha5, 8'hff, 8'h00, 8'h81};
    foreach (words[i]) begin
      host_model_inst.send(words[i], 1'b1);
      wait_sink(words[i]);
      check("sink", sink_output, words[i]);
      check("ready", latch_ready, 1'b1);
    end
    $display("test words done");
  endtask : t_words

  task automatic t_cascade();
    logic [7:0] w;
    logic [7:0] shadow;
    w = 8'h3c;
    shadow = 8'h81;
    fork
      host_model_inst.send(w, 1'b0);
      for (int i = 7; i >= 0; i--) begin
        @(posedge shift_clock);
        #40 @(negedge clk);
        check("cascade before fall", cascade_data_out, shadow[7]);
        shadow = {shadow[6:0], w[i]};
        @(negedge shift_clock);
        #48 @(negedge clk);
        check("cascade", cascade_data_out, shadow[7]);
      end
    join
    check("sink held", sink_output, 8'h81);
    $display("test cascade done");
  endtask : t_cascade

  task automatic t_enable();
    @(posedge clk) out_enable_n <= 1'b1;
    wait_sink(8'h00);
    check("sink off", sink_output, 8'h00);
    @(posedge clk) out_enable_n <= 1'b0;
    wait_sink(8'h81);
    check("sink back", sink_output, 8'h81);
    $display("test enable done");
  endtask : t_enable

  task automatic t_clear();
    host_model_inst.send(8'hff, 1'b0);
    @(posedge clk) clear_n <= 1'b0;
    wait_sink(8'h00);
    check("sink clear", sink_output, 8'h00);
    check("cascade clear", cascade_data_out, 1'b0);
    host_model_inst.send(8'hff, 1'b1);
    check("sink ignored", sink_output, 8'h00);
    @(posedge clk) clear_n <= 1'b1;
    repeat (10) @(negedge clk);
    check("storage cleared", sink_output, 8'h00);
    check("shift cleared", cascade_data_out, 1'b0);
    host_model_inst.pulse_latch();
    check("latched shift", sink_output, 8'h00);
    $display("test clear done");
  endtask : t_clear

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    out_enable_n <= 1'b0;
    repeat (4) @(negedge clk);
    t_words();
    t_cascade();
    t_enable();
    t_clear();
    stop_test();
  end
endmodule : testbench

// file: hw/capture_fifo.sv
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: width and depth are parameters; depth a power of two
`timescale 1ns/1ps
module capture_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff < (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      case ({push, pop})
        2'b10: count_ff <= count_ff + 1'b1;
        2'b01: count_ff <= count_ff - 1'b1;
        default: count_ff <= count_ff;
      endcase
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
    count_ff <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : capture_fifo

// file: hw/latch_driver.sv
// Purpose: serial-in shift stage, storage stage and gated sink outputs
// Assumes: pins sampled by clk through three flops; rst_b is system reset
// Notes: every latched word passes an 8-deep fifo before the outputs
// What this block does
// - eight-bit shift register feeds eight-bit edge-triggered storage
// - shift clock rising edge shifts serial input into first stage
// - latch clock rising edge copies all eight shift stages into storage
// - storage contents pass to outputs only while clear_n is high
// - clear_n low clears shift and storage stages to zero
// - output enable high forces all sink outputs off
// - output enable low makes outputs follow storage three clk cycles behind, through fifo and buffer
// - cascade output updates on shift clock falling edge
// - low buffer bit leaves that sink output off
// - high buffer bit turns that sink output on while output enable is low
`timescale 1ns/1ps
module latch_driver
  import latch_driver_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic shift_clock,
  input wire logic latch_clock,
  input wire logic shift_data_in,
  input wire logic clear_n,
  input wire logic out_enable_n,
  output logic cascade_data_out,
  output logic [STAGE_W-1:0] sink_output,
  output logic latch_ready
);
  logic [SYNC_LEN-1:0] sck_sync_ff;
  logic [SYNC_LEN-1:0] lck_sync_ff;
  logic [SYNC_LEN-1:0] din_sync_ff;
  logic [SYNC_LEN-1:0] clr_sync_ff;
  logic [SYNC_LEN-1:0] oen_sync_ff;
  logic sck_level_ff;
  logic lck_level_ff;
  logic din_level_ff;
  logic clr_n_level_ff;
  logic oen_n_level_ff;
  logic sck_rise;
  logic sck_fall;
  logic lck_rise;
  logic [STAGE_W-1:0] shift_ff;
  logic [STAGE_W-1:0] storage_ff;
  logic [STAGE_W-1:0] nxt_storage;
  logic cascade_ff;
  logic [STAGE_W-1:0] sink_ff;
  logic [STAGE_W-1:0] buffer_ff;
  logic fifo_out_valid;
  logic [STAGE_W-1:0] fifo_out_data;
  logic fifo_in_ready;

  // three-flop sampling; a level changes once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sck_sync_ff <= SYNC_CLEAR;
      lck_sync_ff <= SYNC_CLEAR;
      din_sync_ff <= SYNC_CLEAR;
      clr_sync_ff <= SYNC_CLEAR;
      oen_sync_ff <= ~SYNC_CLEAR;
    end else begin
      sck_sync_ff <= {sck_sync_ff[1:0], shift_clock};
      lck_sync_ff <= {lck_sync_ff[1:0], latch_clock};
      din_sync_ff <= {din_sync_ff[1:0], shift_data_in};
      clr_sync_ff <= {clr_sync_ff[1:0], clear_n};
      oen_sync_ff <= {oen_sync_ff[1:0], out_enable_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sck_level_ff <= 1'b0;
      lck_level_ff <= 1'b0;
      din_level_ff <= 1'b0;
      clr_n_level_ff <= 1'b0;
      oen_n_level_ff <= 1'b1;
    end else begin
      if (sck_sync_ff[1] == sck_sync_ff[2]) begin
        sck_level_ff <= sck_sync_ff[2];
      end
      if (lck_sync_ff[1] == lck_sync_ff[2]) begin
        lck_level_ff <= lck_sync_ff[2];
      end
      if (din_sync_ff[1] == din_sync_ff[2]) begin
        din_level_ff <= din_sync_ff[2];
      end
      if (clr_sync_ff[1] == clr_sync_ff[2]) begin
        clr_n_level_ff <= clr_sync_ff[2];
      end
      if (oen_sync_ff[1] == oen_sync_ff[2]) begin
        oen_n_level_ff <= oen_sync_ff[2];
      end
    end
  end

  assign sck_rise = (sck_sync_ff[1] == sck_sync_ff[2]) &&
                    sck_sync_ff[2] && !sck_level_ff;
  assign sck_fall = (sck_sync_ff[1] == sck_sync_ff[2]) &&
                    !sck_sync_ff[2] && sck_level_ff;
  assign lck_rise = (lck_sync_ff[1] == lck_sync_ff[2]) &&
                    lck_sync_ff[2] && !lck_level_ff;

  // shift stage: data moves from stage 0 toward the last stage
  always_ff @(posedge clk) begin
    if (!rst_b || !clr_n_level_ff) begin
      shift_ff <= STAGE_CLEAR;
    end else if (sck_rise) begin
      shift_ff <= {shift_ff[LAST_STAGE-1:0], din_level_ff};
    end
  end

  // storage stage, a parallel copy on the latch edge
  always_comb begin
    nxt_storage = storage_ff;
    if (lck_rise) begin
      nxt_storage = shift_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !clr_n_level_ff) begin
      storage_ff <= STAGE_CLEAR;
    end else begin
      storage_ff <= nxt_storage;
    end
  end

  // cascade bit launched on the falling edge for downstream hold margin
  always_ff @(posedge clk) begin
    if (!rst_b || !clr_n_level_ff) begin
      cascade_ff <= 1'b0;
    end else if (sck_fall) begin
      cascade_ff <= shift_ff[LAST_STAGE];
    end
  end
  assign cascade_data_out = cascade_ff;

  // each storage word is queued; buffer takes the oldest one out
  capture_fifo #(
    .WIDTH(STAGE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b && clr_n_level_ff),
    .in_valid(clr_n_level_ff),
    .in_ready(fifo_in_ready),
    .in_data(storage_ff),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );
  assign latch_ready = fifo_in_ready;

  always_ff @(posedge clk) begin
    if (!rst_b || !clr_n_level_ff) begin
      buffer_ff <= STAGE_CLEAR;
    end else if (fifo_out_valid) begin
      buffer_ff <= fifo_out_data;
    end
  end

  // gating by enable, per channel
  genvar ch;
  generate
    for (ch = FIRST_STAGE; ch < STAGE_W; ch++) begin : g_sink
      always_ff @(posedge clk) begin
        if (!rst_b || oen_n_level_ff) begin
          sink_ff[ch] <= 1'b0;
        end else begin
          sink_ff[ch] <= buffer_ff[ch];
        end
      end
    end
  endgenerate
  assign sink_output = sink_ff;

  sequence latch_edge_s;
    lck_rise && clr_n_level_ff;
  endsequence

  // named steps shared by the checks below
  sequence shift_edge_s;
    sck_rise && clr_n_level_ff;
  endsequence

  sequence cascade_edge_s;
    sck_fall && clr_n_level_ff;
  endsequence

  sequence clear_seen_s;
    !clr_n_level_ff;
  endsequence

  sequence quiet_shift_s;
    !sck_rise && clr_n_level_ff;
  endsequence

  sequence quiet_latch_s;
    !lck_rise && clr_n_level_ff;
  endsequence

  sequence quiet_fall_s;
    !sck_fall && clr_n_level_ff;
  endsequence

  // latch edge, then three cycles with clear released
  sequence latch_walk_s;
    latch_edge_s ##1 clr_n_level_ff ##1 clr_n_level_ff ##1 clr_n_level_ff;
  endsequence

  latch_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
    latch_edge_s |=> storage_ff == $past(shift_ff))
    else $error("storage did not copy shift stage");
  shift_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    shift_edge_s |=>
      shift_ff == {$past(shift_ff[LAST_STAGE-1:0]), $past(din_level_ff)})
    else $error("shift stage did not advance");
  clear_all_a: assert property (@(posedge clk) disable iff (!rst_b)
    clear_seen_s |=> shift_ff == STAGE_CLEAR && storage_ff == STAGE_CLEAR)
    else $error("clear did not empty stages");
  enable_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    oen_n_level_ff |=> sink_output == STAGE_CLEAR)
    else $error("outputs on while disabled");
  enable_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    !oen_n_level_ff |=> sink_output == $past(buffer_ff))
    else $error("outputs not following buffer");
  cascade_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(cascade_ff) |-> $past(sck_fall) || !$past(clr_n_level_ff))
    else $error("cascade changed off falling edge");
  cascade_last_a: assert property (@(posedge clk) disable iff (!rst_b)
    cascade_edge_s |=> cascade_ff == $past(shift_ff[LAST_STAGE]))
    else $error("cascade not last stage");
  buffer_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    clr_n_level_ff && $past(clr_n_level_ff) && $past(clr_n_level_ff, 2)
      && $past(clr_n_level_ff, 3)
      |-> ##2 buffer_ff == $past(storage_ff, 2) || !clr_n_level_ff)
    else $error("buffer did not take storage");
  sink_on_a: assert property (@(posedge clk) disable iff (!rst_b)
    !oen_n_level_ff && buffer_ff[0] |=> sink_output[0])
    else $error("channel not on");
  sink_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !buffer_ff[0] |=> !sink_output[0])
    else $error("channel not off");

  first_stage_a: assert property (@(posedge clk) disable iff (!rst_b)
    shift_edge_s |=> shift_ff[FIRST_STAGE] == $past(din_level_ff))
    else $error("first stage did not take serial input");
  shift_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    quiet_shift_s |=> shift_ff == $past(shift_ff))
    else $error("shift stage moved without an edge");
  storage_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    quiet_latch_s |=> storage_ff == $past(storage_ff))
    else $error("storage moved without a latch edge");
  cascade_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    quiet_fall_s |=> cascade_ff == $past(cascade_ff))
    else $error("cascade moved without a falling edge");
  cascade_port_a: assert property (@(posedge clk) disable iff (!rst_b)
    cascade_edge_s |=> cascade_data_out == $past(shift_ff[LAST_STAGE]))
    else $error("cascade pin not last stage");
  clear_sink_a: assert property (@(posedge clk) disable iff (!rst_b)
    clear_seen_s |=> ##1 sink_output == STAGE_CLEAR)
    else $error("outputs on after clear");
  clear_cascade_a: assert property (@(posedge clk) disable iff (!rst_b)
    clear_seen_s |=> !cascade_data_out)
    else $error("cascade set after clear");
  clear_buffer_a: assert property (@(posedge clk) disable iff (!rst_b)
    clear_seen_s |=> buffer_ff == STAGE_CLEAR)
    else $error("buffer passed data during clear");
  latch_reach_a: assert property (@(posedge clk) disable iff (!rst_b)
    latch_walk_s |-> buffer_ff == $past(shift_ff, 3))
    else $error("latched word did not reach buffer");
  sink_reach_a: assert property (@(posedge clk) disable iff (!rst_b)
    latch_walk_s ##0 !oen_n_level_ff |=> sink_output == $past(shift_ff, 4))
    else $error("latched word did not reach outputs");

  // a level is taken only once stages two and three agree
  sck_agree_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(sck_level_ff) |->
      $past(sck_sync_ff[1]) == $past(sck_sync_ff[2]))
    else $error("shift clock taken before stages agreed");
  lck_agree_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(lck_level_ff) |->
      $past(lck_sync_ff[1]) == $past(lck_sync_ff[2]))
    else $error("latch clock taken before stages agreed");
  din_agree_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(din_level_ff) |->
      $past(din_sync_ff[1]) == $past(din_sync_ff[2]))
    else $error("serial input taken before stages agreed");
  clr_agree_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(clr_n_level_ff) |->
      $past(clr_sync_ff[1]) == $past(clr_sync_ff[2]))
    else $error("clear taken before stages agreed");
  oen_agree_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(oen_n_level_ff) |->
      $past(oen_sync_ff[1]) == $past(oen_sync_ff[2]))
    else $error("enable taken before stages agreed");

  // every channel, not only the first, obeys the on and off rules
  generate
    for (ch = FIRST_STAGE; ch < STAGE_W; ch++) begin : g_sink_chk
      chan_on_a: assert property (@(posedge clk) disable iff (!rst_b)
        !oen_n_level_ff && buffer_ff[ch] |=> sink_output[ch])
        else $error("sink channel not on");
      chan_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        !buffer_ff[ch] |=> !sink_output[ch])
        else $error("sink channel not off");
    end
  endgenerate
endmodule : latch_driver

// file: inc/latch_driver_pkg.sv
// Purpose: shared constants for the serial-in latched output driver
// Assumes: one 125 MHz system clock, pin inputs sampled by it
// Notes: fifo depth and width fixed at the stage width
package latch_driver_pkg;
  localparam int STAGE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_LEN = 3;
  localparam logic [7:0] STAGE_CLEAR = 8'h00;
  localparam logic [2:0] SYNC_CLEAR = 3'h0;
  localparam int LAST_STAGE = STAGE_W - 1;
  localparam int FIRST_STAGE = 0;
endpackage : latch_driver_pkg
